// File: hdl/gst_pkg.sv
// package with register map, field positions and reset values of the gated timer
package gst_pkg;
  // register indices, not byte offsets, so the byte address is index * 4
  localparam logic [11:0] GST_IDX_COUNT_CONTROL = 12'hF79;
  localparam logic [11:0] GST_IDX_OSC_CONTROL_TWO = 12'hF87;
  localparam logic [11:0] GST_IDX_GATE_CONTROL = 12'hF97;
  localparam logic [11:0] GST_IDX_COUNT_LOW = 12'hF7A;
  localparam logic [11:0] GST_IDX_COUNT_HIGH = 12'hF7B;
  localparam logic [11:0] GST_IDX_STATUS = 12'hF7C;
  localparam int GST_ADDR_W = 14;
  // count_control fields
  localparam int GST_CC_RUN = 0;
  localparam int GST_CC_WIDE = 1;
  localparam int GST_CC_SYNC = 2;
  localparam int GST_CC_OSCEN = 3;
  localparam int GST_CC_PS_LO = 4;
  localparam int GST_CC_CS_LO = 6;
  // gate_control fields
  localparam int GST_GC_SS_LO = 0;
  localparam int GST_GC_VAL = 2;
  localparam int GST_GC_GO = 3;
  localparam int GST_GC_SPM = 4;
  localparam int GST_GC_TM = 5;
  localparam int GST_GC_POL = 6;
  localparam int GST_GC_EN = 7;
  // oscillator_control_two fields
  localparam int GST_OC_PRI = 2;
  localparam int GST_OC_GO = 3;
  localparam int GST_OC_DRV = 4;
  localparam int GST_OC_RUN = 6;
  localparam logic [7:0] GST_OC_WMASK = 8'h1C;
  // status fields
  localparam int GST_ST_OVF = 0;
  localparam int GST_ST_GEV = 1;
  // reset values
  localparam logic [7:0] GST_CC_RST = 8'h00;
  localparam logic [7:0] GST_GC_RST = 8'h00;
  localparam logic [7:0] GST_OC_RST = 8'h14;
  // clock source encodings and last instruction divider count
  localparam logic [1:0] GST_CS_INSTR = 2'h0;
  localparam logic [1:0] GST_CS_SYS = 2'h1;
  localparam logic [1:0] GST_CS_EXT = 2'h2;
  localparam logic [1:0] GST_INSTR_DIV_LAST = 2'h3;
  // axi response codes
  localparam logic [1:0] GST_RESP_OKAY = 2'h0;
  localparam logic [1:0] GST_RESP_SLVERR = 2'h2;
endpackage

// File: hdl/gst_timer.sv
// gated sixteen bit timer with axi4-lite register access
`timescale 1ns/1ps
module gst_timer
  import gst_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write channels
  input wire logic [GST_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [GST_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // count and gate sources, oscillator status inputs
  input wire logic externalCountInput,
  input wire logic secondaryOscClk,
  input wire logic gateInputPin,
  input wire logic companionMatch,
  input wire logic comparator1,
  input wire logic comparator2,
  input wire logic sysClkFromSecondary,
  input wire logic secondaryOscDigital,
  input wire logic secondaryOscRequest,
  // oscillator controls and overflow flag
  output logic secondaryOscDriveCfg,
  output logic secondaryOscEnable,
  output logic primaryDriveOn,
  output logic overflowFlag
);

  // register state
  logic [7:0] countCtl_r;
  logic [7:0] gateCtl_r;
  logic [7:0] oscCtl_r;
  logic [15:0] count_r;
  logic [7:0] highBuf_r;
  logic [2:0] prescale_r;
  logic [1:0] instrDiv_r;
  logic [1:0] extSync_r;
  logic extPrev_r;
  logic extArmed_r;
  logic gateSrc_r;
  logic toggleFf_r;
  logic goBit_r;
  logic spmEnable_r;
  logic gateLevel_r;
  logic ovf_r;
  logic gateEvent_r;
  // bus state
  logic awHeld_r;
  logic wHeld_r;
  logic [GST_ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] bResp_r;
  logic [1:0] rResp_r;
  logic secOscEn_r;
  logic [15:0] count_nxt;
  logic [7:0] highBuf_nxt;

  // word index of a byte address; the low two address bits are ignored
  function automatic logic [11:0] regIndex(input logic [GST_ADDR_W-1:0] a);
    return a[GST_ADDR_W-1:2];
  endfunction

  // write path decode
  wire doWrite = awHeld_r && wHeld_r && !bValid_r;
  wire [11:0] wIdx = regIndex(awAddr_r);
  wire wLane0 = wStrb_r[0];
  wire wrCc = doWrite && wLane0 && wIdx == GST_IDX_COUNT_CONTROL;
  wire wrGc = doWrite && wLane0 && wIdx == GST_IDX_GATE_CONTROL;
  wire wrOc = doWrite && wLane0 && wIdx == GST_IDX_OSC_CONTROL_TWO;
  wire wrLow = doWrite && wLane0 && wIdx == GST_IDX_COUNT_LOW;
  wire wrHigh = doWrite && wLane0 && wIdx == GST_IDX_COUNT_HIGH;
  wire wrSt = doWrite && wLane0 && wIdx == GST_IDX_STATUS;
  wire wMapped = wIdx == GST_IDX_COUNT_CONTROL || wIdx == GST_IDX_GATE_CONTROL ||
                 wIdx == GST_IDX_OSC_CONTROL_TWO || wIdx == GST_IDX_COUNT_LOW ||
                 wIdx == GST_IDX_COUNT_HIGH || wIdx == GST_IDX_STATUS;
  wire [7:0] wByte = wData_r[7:0];
  // read path decode
  wire doRead = s_axi_arvalid && !rValid_r;
  wire [11:0] rIdx = regIndex(s_axi_araddr);
  wire rdLow = doRead && rIdx == GST_IDX_COUNT_LOW;
  // control fields
  wire timerRun = countCtl_r[GST_CC_RUN];
  wire wideMode = countCtl_r[GST_CC_WIDE];
  wire syncBypass = countCtl_r[GST_CC_SYNC];
  wire oscInputEn = countCtl_r[GST_CC_OSCEN];
  wire [1:0] psSel = countCtl_r[GST_CC_PS_LO +: 2];
  wire [1:0] csSel = countCtl_r[GST_CC_CS_LO +: 2];
  wire [1:0] gssSel = gateCtl_r[GST_GC_SS_LO +: 2];
  // external source select; raw path skips the two-stage synchroniser
  wire extRaw = oscInputEn ? secondaryOscClk : externalCountInput;
  wire extLevel = syncBypass ? extRaw : extSync_r[1];
  wire extRise = extLevel && !extPrev_r;
  wire extFall = !extLevel && extPrev_r;
  // base tick per selected clock source
  wire srcTick = csSel == GST_CS_INSTR ? instrDiv_r == GST_INSTR_DIV_LAST :
                 csSel == GST_CS_SYS ? 1'b1 :
                 csSel == GST_CS_EXT ? extRise && extArmed_r : 1'b0;
  // gate source, polarity, toggle and single pulse chain
  wire gateSel = gssSel == 2'h0 ? gateInputPin : gssSel == 2'h1 ? companionMatch :
                 gssSel == 2'h2 ? comparator1 : comparator2;
  wire gatePol = gateCtl_r[GST_GC_POL] ? gateSel : !gateSel;
  wire gateRise = gatePol && !gateSrc_r;
  wire gateAfterTm = gateCtl_r[GST_GC_TM] ? toggleFf_r : gatePol;
  wire gateLive = gateCtl_r[GST_GC_SPM] ? (gateAfterTm && spmEnable_r) : gateAfterTm;
  wire gateOk = !gateCtl_r[GST_GC_EN] || gateLive;
  // prescaler divides source ticks by 1, 2, 4 or 8
  wire [2:0] psMask = 3'((4'h1 << psSel) - 4'h1);
  wire psTick = srcTick && ((prescale_r & psMask) == psMask);
  wire countTick = timerRun && gateOk && psTick;
  wire wrap = countTick && count_r == 16'hFFFF;

  // counter and high buffer next values, bus write beats the increment
  always_comb begin
    count_nxt = countTick ? 16'(count_r + 16'h0001) : count_r;
    highBuf_nxt = highBuf_r;
    if (wrLow) begin
      count_nxt[7:0] = wByte;
      if (wideMode) begin
        count_nxt[15:8] = highBuf_r;
      end
    end
    if (wrHigh) begin
      if (wideMode) begin
        highBuf_nxt = wByte;
      end else begin
        count_nxt[15:8] = wByte;
      end
    end
    if (rdLow && wideMode) begin
      highBuf_nxt = count_r[15:8];
    end
  end

  // counting datapath
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 16'h0000;
      highBuf_r <= 8'h00;
      prescale_r <= 3'h0;
      instrDiv_r <= 2'h0;
      extSync_r <= 2'h0;
      extPrev_r <= 1'b0;
      extArmed_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      highBuf_r <= highBuf_nxt;
      instrDiv_r <= 2'(instrDiv_r + 2'h1);
      extSync_r <= {extSync_r[0], extRaw};
      extPrev_r <= extLevel;
      if (wrLow) begin
        prescale_r <= 3'h0;
      end else if (srcTick && timerRun && gateOk) begin
        prescale_r <= 3'(prescale_r + 3'h1);
      end
      // arm on first falling edge after counting starts
      if (!timerRun || csSel != GST_CS_EXT) begin
        extArmed_r <= 1'b0;
      end else if (extFall) begin
        extArmed_r <= 1'b1;
      end
    end
  end

  // gate state: toggle flip-flop, single pulse, live level and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gateSrc_r <= 1'b0;
      toggleFf_r <= 1'b0;
      goBit_r <= 1'b0;
      spmEnable_r <= 1'b0;
      gateLevel_r <= 1'b0;
      ovf_r <= 1'b0;
      gateEvent_r <= 1'b0;
    end else begin
      gateSrc_r <= gatePol;
      gateLevel_r <= gateLive;
      if (!gateCtl_r[GST_GC_TM]) begin
        toggleFf_r <= 1'b0;
      end else if (gateRise) begin
        toggleFf_r <= !toggleFf_r;
      end
      // go arms acquisition; enable opens while the gate is active, closes on trailing edge
      if (!gateCtl_r[GST_GC_SPM]) begin
        goBit_r <= 1'b0;
        spmEnable_r <= 1'b0;
      end else if (wrGc && wByte[GST_GC_GO] && wByte[GST_GC_SPM]) begin
        goBit_r <= 1'b1;
      end else if (goBit_r && gateAfterTm && !spmEnable_r) begin
        spmEnable_r <= 1'b1;
      end else if (spmEnable_r && !gateAfterTm) begin
        spmEnable_r <= 1'b0;
        goBit_r <= 1'b0;
      end
      // flags: set wins over a write-one-to-clear in the same cycle
      if (wrap) begin
        ovf_r <= 1'b1;
      end else if (wrSt && wByte[GST_ST_OVF]) begin
        ovf_r <= 1'b0;
      end
      if (gateLevel_r && !gateLive) begin
        gateEvent_r <= 1'b1;
      end else if (wrSt && wByte[GST_ST_GEV]) begin
        gateEvent_r <= 1'b0;
      end
    end
  end

  // control registers; gate control should be written first by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countCtl_r <= GST_CC_RST;
      gateCtl_r <= GST_GC_RST;
      oscCtl_r <= GST_OC_RST;
      secOscEn_r <= 1'b0;
    end else begin
      if (wrCc) begin
        countCtl_r <= wByte;
      end
      if (wrGc) begin
        gateCtl_r <= wByte;
      end
      if (wrOc) begin
        oscCtl_r <= wByte & GST_OC_WMASK;
      end
      secOscEn_r <= secondaryOscRequest || (oscCtl_r[GST_OC_GO] && !secondaryOscDigital);
    end
  end

  // readback mux; acquire-go and gate level are live bits
  wire [7:0] gcRead = {gateCtl_r[7:4], goBit_r, gateLevel_r, gssSel};
  wire [7:0] ocRead = {1'b0, sysClkFromSecondary, 1'b0, oscCtl_r[4:2], 2'h0};
  wire [7:0] hiRead = wideMode ? highBuf_r : count_r[15:8];
  wire rMapped = rIdx == GST_IDX_COUNT_CONTROL || rIdx == GST_IDX_GATE_CONTROL ||
                 rIdx == GST_IDX_OSC_CONTROL_TWO || rIdx == GST_IDX_COUNT_LOW ||
                 rIdx == GST_IDX_COUNT_HIGH || rIdx == GST_IDX_STATUS;
  wire [7:0] rByte = rIdx == GST_IDX_COUNT_CONTROL ? countCtl_r :
                     rIdx == GST_IDX_GATE_CONTROL ? gcRead :
                     rIdx == GST_IDX_OSC_CONTROL_TWO ? ocRead :
                     rIdx == GST_IDX_COUNT_LOW ? count_r[7:0] :
                     rIdx == GST_IDX_COUNT_HIGH ? hiRead :
                     rIdx == GST_IDX_STATUS ? {6'h00, gateEvent_r, ovf_r} : 8'h00;

  // axi write channel: address and data taken independently, one response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= GST_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r <= wMapped ? GST_RESP_OKAY : GST_RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
    end
  end

  // axi read channel: address taken when no read data is pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= GST_RESP_OKAY;
    end else if (doRead) begin
      rValid_r <= 1'b1;
      rData_r <= {24'h000000, rByte};
      rResp_r <= rMapped ? GST_RESP_OKAY : GST_RESP_SLVERR;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready = !wHeld_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign secondaryOscDriveCfg = oscCtl_r[GST_OC_DRV];
  assign secondaryOscEnable = secOscEn_r;
  assign primaryDriveOn = oscCtl_r[GST_OC_PRI];
  assign overflowFlag = ovf_r;

  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_run_holds_count: assert property (!timerRun && !wrLow && !wrHigh |=> $stable(count_r))
    else $error("count moved while stopped");
  a_wrap_sets_ovf: assert property (wrap && !wrLow && !wrHigh |=> ovf_r && count_r == 16'h0000)
    else $error("wrap lost");
  a_low_clears_ps: assert property (wrLow |=> prescale_r == 3'h0) else $error("prescaler not cleared");
  a_wide_rd_latch: assert property (rdLow && wideMode |=> highBuf_r == $past(count_r[15:8]))
    else $error("buffer not latched");
  a_wide_wr_load: assert property (wrLow && wideMode |=> count_r[15:8] == $past(highBuf_r))
    else $error("high not loaded");
  a_tm_off_clear: assert property (!gateCtl_r[GST_GC_TM] |=> !toggleFf_r) else $error("toggle ff not held");
  a_spm_off_go: assert property (!gateCtl_r[GST_GC_SPM] |=> !goBit_r) else $error("go not cleared");
  a_gate_fall_ev: assert property (gateLevel_r && !gateLive |=> gateEvent_r) else $error("gate event lost");
  a_gate_blocks: assert property (timerRun && gateCtl_r[GST_GC_EN] && !gateLive && !wrLow && !wrHigh
    |=> $stable(count_r)) else $error("gated count moved");
  a_ext_unarmed: assert property (timerRun && csSel == GST_CS_EXT && !extArmed_r && !wrLow && !wrHigh
    |=> $stable(count_r)) else $error("counted before arm");
  c_wrap: cover property (wrap);
  c_spm_done: cover property (spmEnable_r ##1 !spmEnable_r && !goBit_r);
  c_ext_count: cover property (countTick && csSel == GST_CS_EXT);
  c_wide_rw: cover property (wrLow && wideMode);
endmodule

// File: dv/gst_far_side.sv
// far-side model: external count pin and secondary oscillator clock sources
`timescale 1ns/1ps
module gst_far_side (
  // clock
  input wire logic clk,
  // run controls from the bench
  input wire logic pinRun,
  input wire logic oscRun,
  // clock levels toward the timer
  output logic externalCountInput,
  output logic secondaryOscClk
);
  logic [1:0] div_r = 2'h0;
  logic pinLevel_r = 1'b0;
  logic oscLevel_r = 1'b0;
  assign externalCountInput = pinLevel_r;
  assign secondaryOscClk = oscLevel_r;
  // eight-cycle period; each source stands still while not running, so no stray edge reaches the timer
  always @(posedge clk) begin
    div_r <= 2'(div_r + 2'h1);
    if (div_r == 2'h3 && pinRun) pinLevel_r <= !pinLevel_r;
    if (div_r == 2'h3 && oscRun) oscLevel_r <= !oscLevel_r;
  end
endmodule

// File: dv/test_gated_sixteen_bit_timer.sv
// self-checking bench for the gated sixteen bit timer
`timescale 1ns/1ps
module test_gated_sixteen_bit_timer;
  import gst_pkg::*;
  localparam logic [11:0] CC = GST_IDX_COUNT_CONTROL;
  localparam logic [11:0] GC = GST_IDX_GATE_CONTROL;
  localparam logic [11:0] OC = GST_IDX_OSC_CONTROL_TWO;
  localparam logic [11:0] LO = GST_IDX_COUNT_LOW;
  localparam logic [11:0] HI = GST_IDX_COUNT_HIGH;
  localparam logic [11:0] ST = GST_IDX_STATUS;
  localparam logic [11:0] BAD = 12'h100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [GST_ADDR_W-1:0] awAddr = '0;
  logic [GST_ADDR_W-1:0] arAddr = '0;
  logic [31:0] wData = '0;
  logic [3:0] wStrb = 4'h0;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [3:0] gateSrc = 4'h0;
  logic sysFromSec = 1'b1;
  logic oscDigital = 1'b0;
  logic oscRequest = 1'b0;
  logic pinRun = 1'b0;
  logic oscRun = 1'b0;
  logic extPin, oscClk, drvCfg, oscEnable, priOn, ovf;
  int errCount = 0;
  int nTests = 0;
  int cycles = 0;

  gst_timer uut (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .externalCountInput(extPin), .secondaryOscClk(oscClk), .gateInputPin(gateSrc[0]),
    .companionMatch(gateSrc[1]), .comparator1(gateSrc[2]), .comparator2(gateSrc[3]),
    .sysClkFromSecondary(sysFromSec), .secondaryOscDigital(oscDigital),
    .secondaryOscRequest(oscRequest), .secondaryOscDriveCfg(drvCfg),
    .secondaryOscEnable(oscEnable), .primaryDriveOn(priOn), .overflowFlag(ovf));

  gst_far_side far (.clk(clk), .pinRun(pinRun), .oscRun(oscRun),
    .externalCountInput(extPin), .secondaryOscClk(oscClk));

  // clock
  initial begin
    forever #10 clk = ~clk;
  end

  // hang guard, well above the few thousand cycles the scenarios need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errCount = errCount + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // tolerance compare for counts whose start edge depends on bus latency
  task automatic near(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
    check(got + tol >= exp && got <= exp + tol, 1'b1);
  endtask

  // one axi4-lite write, address and data offered together, each released when taken
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk);
    awAddr <= {idx, 2'h0};
    wData <= {24'h0, d};
    wStrb <= 4'h1;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (!(bValid && bReady));
    bReady <= 1'b0;
    check(bResp, (idx == BAD) ? GST_RESP_SLVERR : GST_RESP_OKAY);
  endtask

  task automatic rd(input logic [11:0] idx, output logic [7:0] d);
    @(posedge clk);
    arAddr <= {idx, 2'h0};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk);
      if (arValid && arReady) arValid <= 1'b0;
    end while (!(rValid && rReady));
    rReady <= 1'b0;
    d = rData[7:0];
    check(rResp, (idx == BAD) ? GST_RESP_SLVERR : GST_RESP_OKAY);
  endtask

  task automatic rdChk(input logic [11:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    rd(idx, d);
    check(d, exp);
  endtask

  // clear the count, run with the given control for a fixed window, stop and read back
  task automatic measure(input logic [7:0] cc, output logic [15:0] n);
    logic [7:0] l, h;
    wr(HI, 8'h00);
    wr(LO, 8'h00);
    wr(CC, cc);
    repeat (200) @(posedge clk);
    wr(CC, cc & 8'hFE);
    rd(LO, l);
    rd(HI, h);
    n = {h, l};
  endtask

  task automatic testRegs();
    logic [7:0] d;
    rdChk(CC, GST_CC_RST);
    rdChk(OC, GST_OC_RST | 8'h40);
    check({drvCfg, priOn}, 2'h3);
    rd(GC, d);
    check(d & 8'hFB, GST_GC_RST);
    rdChk(BAD, 8'h00);
    wr(BAD, 8'hFF);
    wr(OC, 8'hE3);
    rdChk(OC, 8'h40);
    check({drvCfg, priOn, oscEnable}, 3'h0);
    sysFromSec <= 1'b0;
    wr(OC, 8'h1C);
    rdChk(OC, 8'h1C);
    check({drvCfg, priOn, oscEnable}, 3'h7);
    oscDigital <= 1'b1;
    repeat (3) @(posedge clk);
    check(oscEnable, 1'b0);
    oscRequest <= 1'b1;
    repeat (3) @(posedge clk);
    check(oscEnable, 1'b1);
  endtask

  task automatic testBytes();
    wr(CC, 8'h00);
    wr(HI, 8'h12);
    wr(LO, 8'h34);
    rdChk(HI, 8'h12);
    rdChk(LO, 8'h34);
    wr(CC, 8'h02);
    wr(HI, 8'h56);
    rdChk(HI, 8'h56);
    rdChk(LO, 8'h34);
    rdChk(HI, 8'h12);
    wr(HI, 8'h9A);
    wr(LO, 8'hBC);
    wr(CC, 8'h00);
    rdChk(HI, 8'h9A);
    rdChk(LO, 8'hBC);
  endtask

  task automatic testClock();
    logic [15:0] c0, c;
    measure(8'h41, c0);
    near(c0, 16'd204, 16'd8);
    for (int p = 1; p < 4; p++) begin
      measure(8'h41 | 8'(p << 4), c);
      near(c, c0 >> p, 16'd1);
    end
    measure(8'h01, c);
    near(c, c0 >> 2, 16'd1);
    pinRun <= 1'b1;
    measure(8'h81, c);
    near(c, c0 >> 3, 16'd2);
    measure(8'h85, c);
    near(c, c0 >> 3, 16'd2);
    measure(8'h89, c);
    check(c, 16'h0);
    pinRun <= 1'b0;
    oscRun <= 1'b1;
    measure(8'h89, c);
    near(c, c0 >> 3, 16'd2);
    oscRun <= 1'b0;
    repeat (20) @(posedge clk);
    rdChk(LO, c[7:0]);
  endtask

  task automatic testOverflow();
    wr(ST, 8'h03);
    check(ovf, 1'b0);
    wr(HI, 8'hFF);
    wr(LO, 8'hFF);
    wr(CC, 8'h41);
    repeat (10) @(posedge clk);
    wr(CC, 8'h40);
    check(ovf, 1'b1);
    rdChk(HI, 8'h00);
    // the flag is sticky: only a write of one to its status bit drops it
    wr(ST, 8'h01);
    check(ovf, 1'b0);
  endtask

  task automatic testGate();
    logic [15:0] c;
    logic [7:0] d;
    for (int s = 0; s < 4; s++) begin
      gateSrc <= 4'(1 << s);
      for (int p = 0; p < 2; p++) begin
        wr(GC, 8'h80 | 8'(p << 6) | 8'(s));
        measure(8'h41, c);
        check(c != 16'h0, p == 1);
      end
      wr(GC, 8'(s));
      measure(8'h41, c);
      check(c != 16'h0, 1'b1);
    end
    wr(GC, 8'h40);
    gateSrc <= 4'h1;
    repeat (4) @(posedge clk);
    wr(ST, 8'h02);
    rd(ST, d);
    check(d[1], 1'b0);
    rd(GC, d);
    check(d[2], 1'b1);
    gateSrc <= 4'h0;
    repeat (4) @(posedge clk);
    rd(GC, d);
    check(d[2], 1'b0);
    rd(ST, d);
    check(d[1], 1'b1);
  endtask

  task automatic pulse();
    gateSrc <= 4'h1;
    repeat (8) @(posedge clk);
    gateSrc <= 4'h0;
    repeat (8) @(posedge clk);
  endtask

  task automatic testPulse();
    logic [7:0] a, b;
    wr(GC, 8'hD0);
    wr(GC, 8'hD8);
    rd(GC, a);
    check(a[3], 1'b1);
    wr(LO, 8'h00);
    wr(CC, 8'h41);
    pulse();
    rd(GC, a);
    check(a[3], 1'b0);
    rd(LO, a);
    pulse();
    rd(LO, b);
    check({a != 8'h0, b}, {1'b1, a});
    wr(GC, 8'hD8);
    wr(GC, 8'hC8);
    rdChk(GC, 8'hC8 & 8'hF7);
    wr(GC, 8'hE0);
    pulse();
    rd(LO, a);
    rd(LO, b);
    check(a != b, 1'b1);
    pulse();
    rd(LO, a);
    rd(LO, b);
    check(b, a);
    wr(CC, 8'h40);
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    testRegs();
    testBytes();
    testClock();
    testOverflow();
    testGate();
    testPulse();
    conclude();
  end
endmodule
